/* src/fpsq_consts.vh */
// Constants for the square-root and subtract datapath slice
`ifndef FPSQ_CONSTS_VH
`define FPSQ_CONSTS_VH
`define FPSQ_OP_SQRT 8'h6e
`define FPSQ_OP_SQFL 8'h6f
`define FPSQ_OP_SUB 8'h71
`define FPSQ_SQRT_LAT 5'h11
`define FPSQ_SQRT_REC 5'h10
`define FPSQ_SUB_LAT 2'h3
`define FPSQ_SLOT_SQRT 3'h2
`define FPSQ_SLOT_SUB_A 3'h1
`define FPSQ_SLOT_SUB_B 3'h4
`define FPSQ_FL_INX 1
`define FPSQ_FL_UNF 2
`define FPSQ_FL_OVF 3
`define FPSQ_FL_INV 4
`define FPSQ_FL_IFZ 5
`define FPSQ_FL_OFZ 6
`define FPSQ_FLW 7
`define FPSQ_RM_LSB 7
`define FPSQ_RM_RNE 2'h0
`define FPSQ_RM_RZ 2'h1
`define FPSQ_RM_RP 2'h2
`define FPSQ_RM_RM 2'h3
`define FPSQ_SW_RST 32'h0
`define FPSQ_QNAN 32'hffffffff
`define FPSQ_INF_MAG 31'h7f800000
`define FPSQ_MAX_MAG 31'h7f7fffff
`define FPSQ_EXP_BIAS 11'h07f
`define FPSQ_EXP_MAX 11'h0ff
`define FPSQ_UNF_EXP 11'sh7ea
`endif

/* src/fpsq_isqrt.v */
// Iterative integer square root, several root bits per clock
`timescale 1ns/1ps
`default_nettype none
module fpsq_isqrt #(
  parameter RW = 54,
  parameter QW = 27,
  parameter SPC = 3
) (
  input wire i_ref_clk, // Clock
  input wire i_rst, // Sync reset
  input wire i_start, // Load new radicand
  input wire [RW-1:0] i_rad, // Radicand
  output reg [QW-1:0] o_root, // Root so far
  output reg o_rem_nz // Remainder nonzero
);
  localparam CYC = QW / SPC;
  reg [RW-1:0] rad_ff;
  reg [QW+1:0] rem_ff;
  reg [4:0] cnt_ff;
  reg [RW-1:0] nxt_rad;
  reg [QW+1:0] nxt_rem;
  reg [QW-1:0] nxt_root;
  reg [QW+1:0] trial;
  integer k;

  // SPC restoring steps per cycle; RW must be 2*QW so steps end exactly
  always @* begin
    nxt_rad = rad_ff;
    nxt_rem = rem_ff;
    nxt_root = o_root;
    trial = {(QW+2){1'b0}};
    for (k = 0; k < SPC; k = k + 1) begin
      nxt_rem = {nxt_rem[QW-1:0], nxt_rad[RW-1:RW-2]};
      nxt_rad = {nxt_rad[RW-3:0], 2'h0};
      trial = {nxt_root, 2'h1};
      if (nxt_rem >= trial) begin
        nxt_rem = nxt_rem - trial;
        nxt_root = {nxt_root[QW-2:0], 1'b1};
      end else begin
        nxt_root = {nxt_root[QW-2:0], 1'b0};
      end
    end
  end

  // Runs CYC cycles after a start, then holds the answer
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      rad_ff <= {RW{1'b0}};
      rem_ff <= {(QW+2){1'b0}};
      o_root <= {QW{1'b0}};
      o_rem_nz <= 1'b0;
      cnt_ff <= 5'h0;
    end else if (i_start) begin
      rad_ff <= i_rad;
      rem_ff <= {(QW+2){1'b0}};
      o_root <= {QW{1'b0}};
      o_rem_nz <= 1'b0;
      cnt_ff <= CYC[4:0];
    end else if (cnt_ff != 5'h0) begin
      rad_ff <= nxt_rad;
      rem_ff <= nxt_rem;
      o_root <= nxt_root;
      o_rem_nz <= (nxt_rem != {(QW+2){1'b0}});
      cnt_ff <= cnt_ff - 5'h1;
    end
  end
endmodule // fpsq_isqrt
`default_nettype wire

/* src/fpsq_top.v */
// Square root, square-root flags and subtract units with status word
`timescale 1ns/1ps
`default_nettype none
`include "fpsq_consts.vh"
module fpsq_top #(
  parameter IDXW = 7
) (
  input wire i_ref_clk, // 100 MHz clock
  input wire i_rst, // Sync reset, active high
  input wire i_issue_vld, // Operation issued this cycle
  input wire [7:0] i_opcode, // Operation code
  input wire [2:0] i_slot, // Issue slot number
  input wire [31:0] i_first_source, // First operand
  input wire [31:0] i_second_source, // Second operand
  input wire i_guard_present, // Guard operand given
  input wire i_guard_lsb, // Guard register bit 0
  input wire [IDXW-1:0] i_dest_idx, // Destination register index
  input wire i_sw_wr, // Explicit status word write
  input wire [31:0] i_sw_wdata, // Status word write data
  input wire [6:0] i_ext_flags, // Flag sets from other units
  output reg o_sub_wr, // Subtract writes destination
  output reg [IDXW-1:0] o_sub_idx, // Subtract destination index
  output reg [31:0] o_sub_data, // Subtract result
  output reg o_sqrt_wr, // Square-root unit writes destination
  output reg [IDXW-1:0] o_sqrt_idx, // Square-root destination index
  output reg [31:0] o_sqrt_data, // Root or flag vector
  output reg o_sqrt_busy, // Square-root unit recovering
  output reg o_refused, // Issue refused pulse
  output reg [31:0] o_status_word // Status word
);
  reg [31:0] sw_ff;
  reg [1:0] rm;

  // Shared round, pack, flush and overflow handling; returns {flags, value}
  function [38:0] fpsq_rnd;
    input s;
    input signed [10:0] e;
    input [26:0] m;
    input [1:0] md;
    reg inexact_flag;
    reg up;
    reg [24:0] r;
    reg signed [10:0] ee;
    reg [6:0] f;
    reg [31:0] v;
    begin
      f = 7'h0;
      inexact_flag = |m[2:0];
      case (md)
        `FPSQ_RM_RNE: up = m[2] & (m[1] | m[0] | m[3]);
        `FPSQ_RM_RZ: up = 1'b0;
        `FPSQ_RM_RP: up = ~s & inexact_flag;
        default: up = s & inexact_flag;
      endcase
      r = {1'b0, m[26:3]} + {24'h0, up};
      ee = e;
      if (r[24]) begin
        ee = e + 11'h1;
        r = {1'b0, r[24:1]};
      end
      if (m == 27'h0) begin
        v = {s, 31'h0};
      end else if (ee <= 11'sh0) begin
        v = {s, 31'h0};
        if (ee <= `FPSQ_UNF_EXP) begin
          f[`FPSQ_FL_UNF] = 1'b1;
        end else begin
          f[`FPSQ_FL_OFZ] = 1'b1;
        end
      end else if (ee >= $signed(`FPSQ_EXP_MAX)) begin
        f[`FPSQ_FL_OVF] = 1'b1;
        f[`FPSQ_FL_INX] = 1'b1;
        // RZ, and RP or RM rounding toward zero, stop at the largest finite value
        if (md == `FPSQ_RM_RNE || (md == `FPSQ_RM_RP && !s) || (md == `FPSQ_RM_RM && s)) begin
          v = {s, `FPSQ_INF_MAG};
        end else begin
          v = {s, `FPSQ_MAX_MAG};
        end
      end else begin
        v = {s, ee[7:0], r[22:0]};
        f[`FPSQ_FL_INX] = inexact_flag;
      end
      fpsq_rnd = {f, v};
    end
  endfunction

  // Rounding mode is read live from the status word
  always @* begin
    rm = sw_ff[`FPSQ_RM_LSB+1:`FPSQ_RM_LSB];
  end

  // Issue decode: slot and recovery checks, guard defaults true
  wire is_sq = (i_opcode == `FPSQ_OP_SQRT) || (i_opcode == `FPSQ_OP_SQFL);
  wire is_sub = (i_opcode == `FPSQ_OP_SUB);
  wire gate = ~i_guard_present | i_guard_lsb;
  reg [4:0] sq_cnt_ff;
  wire sq_free = (sq_cnt_ff == 5'h0) || (sq_cnt_ff >= `FPSQ_SQRT_REC);
  wire sq_acc = i_issue_vld & is_sq & (i_slot == `FPSQ_SLOT_SQRT) & sq_free;
  wire sub_acc = i_issue_vld & is_sub &
    ((i_slot == `FPSQ_SLOT_SUB_A) || (i_slot == `FPSQ_SLOT_SUB_B));
  wire refuse = i_issue_vld & ~sq_acc & ~sub_acc;

  // Square-root operand classification at issue
  wire [7:0] qe = i_first_source[30:23];
  wire [22:0] qm = i_first_source[22:0];
  wire q_dn = (qe == 8'h0) && (qm != 23'h0);
  wire q_zero = (qe == 8'h0);
  wire q_nan = (qe == 8'hff) && (qm != 23'h0);
  wire q_inf = (qe == 8'hff) && (qm == 23'h0);
  reg q_spec;
  reg [31:0] q_sval;
  reg [6:0] q_sfl;
  always @* begin
    q_spec = 1'b1;
    q_sval = `FPSQ_QNAN;
    q_sfl = 7'h0;
    if (q_nan) begin
      q_sfl[`FPSQ_FL_INV] = ~qm[22];
    end else if (q_zero) begin
      q_sval = {i_first_source[31], 31'h0};
      q_sfl[`FPSQ_FL_IFZ] = q_dn;
    end else if (i_first_source[31]) begin
      q_sfl[`FPSQ_FL_INV] = 1'b1;
    end else if (q_inf) begin
      q_sval = {1'b0, `FPSQ_INF_MAG};
    end else begin
      q_spec = 1'b0;
    end
  end
  // Odd unbiased exponent: scale radicand one extra bit so the exponent halves exactly
  wire [53:0] q_rad = qe[0] ? {1'b0, 1'b1, qm, 29'h0} : {1'b1, qm, 30'h0};
  wire [10:0] q_t = {3'h0, qe} - `FPSQ_EXP_BIAS - {10'h0, ~qe[0]};
  wire [10:0] q_exp = {q_t[10], q_t[10:1]} + `FPSQ_EXP_BIAS;

  wire [26:0] root;
  wire rem_nz;
  fpsq_isqrt #(.RW(54), .QW(27), .SPC(3)) u_isqrt (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(sq_acc),
    .i_rad(q_rad),
    .o_root(root),
    .o_rem_nz(rem_nz)
  );

  // Square-root issue capture and latency counter
  reg sq_gate_ff, sq_isfl_ff, sq_spec_ff;
  reg [IDXW-1:0] sq_idx_ff;
  reg [31:0] sq_sval_ff;
  reg [6:0] sq_sfl_ff;
  reg [10:0] sq_exp_ff;
  reg [1:0] sq_rm_ff;
  reg [4:0] nxt_sq_cnt;
  always @* begin
    if (sq_acc) begin
      nxt_sq_cnt = 5'h1;
    end else if (sq_cnt_ff != 5'h0 && sq_cnt_ff < `FPSQ_SQRT_REC) begin
      nxt_sq_cnt = sq_cnt_ff + 5'h1;
    end else begin
      nxt_sq_cnt = 5'h0;
    end
  end
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      sq_cnt_ff <= 5'h0;
      sq_gate_ff <= 1'b0;
      sq_isfl_ff <= 1'b0;
      sq_spec_ff <= 1'b0;
      sq_idx_ff <= {IDXW{1'b0}};
      sq_sval_ff <= 32'h0;
      sq_sfl_ff <= 7'h0;
      sq_exp_ff <= 11'h0;
      sq_rm_ff <= 2'h0;
    end else begin
      sq_cnt_ff <= nxt_sq_cnt;
      if (sq_acc) begin
        sq_gate_ff <= gate;
        sq_isfl_ff <= (i_opcode == `FPSQ_OP_SQFL);
        sq_spec_ff <= q_spec;
        sq_idx_ff <= i_dest_idx;
        sq_sval_ff <= q_sval;
        sq_sfl_ff <= q_sfl;
        sq_exp_ff <= q_exp;
        sq_rm_ff <= rm;
      end
    end
  end

  // Final rounding of the root; a normal operand never gives a tiny root
  wire [38:0] sq_rnd = fpsq_rnd(1'b0, sq_exp_ff, {root[26:1], root[0] | rem_nz}, sq_rm_ff);
  wire [31:0] sq_val = sq_spec_ff ? sq_sval_ff : sq_rnd[31:0];
  wire [6:0] sq_fl = sq_spec_ff ? sq_sfl_ff : sq_rnd[38:32];
  wire sq_fin = (sq_cnt_ff == `FPSQ_SQRT_REC); // Two edges before the write at 17

  // Result stage one edge before the write, so a recovery-time issue can reuse the unit
  reg sq_st_vld_ff, sq_st_gate_ff, sq_st_isfl_ff;
  reg [IDXW-1:0] sq_st_idx_ff;
  reg [31:0] sq_st_val_ff;
  reg [6:0] sq_st_fl_ff;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      sq_st_vld_ff <= 1'b0;
      sq_st_gate_ff <= 1'b0;
      sq_st_isfl_ff <= 1'b0;
      sq_st_idx_ff <= {IDXW{1'b0}};
      sq_st_val_ff <= 32'h0;
      sq_st_fl_ff <= 7'h0;
    end else begin
      sq_st_vld_ff <= sq_fin;
      sq_st_gate_ff <= sq_gate_ff;
      sq_st_isfl_ff <= sq_isfl_ff;
      sq_st_idx_ff <= sq_idx_ff;
      sq_st_val_ff <= sq_val;
      sq_st_fl_ff <= sq_fl;
    end
  end

  // Subtract stage 1: operands captured at issue
  reg s1_vld_ff, s1_gate_ff;
  reg [IDXW-1:0] s1_idx_ff;
  reg [31:0] s1_a_ff, s1_b_ff;
  reg [1:0] s1_rm_ff;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      s1_vld_ff <= 1'b0;
      s1_gate_ff <= 1'b0;
      s1_idx_ff <= {IDXW{1'b0}};
      s1_a_ff <= 32'h0;
      s1_b_ff <= 32'h0;
      s1_rm_ff <= 2'h0;
    end else begin
      s1_vld_ff <= sub_acc;
      if (sub_acc) begin
        s1_gate_ff <= gate;
        s1_idx_ff <= i_dest_idx;
        s1_a_ff <= i_first_source;
        s1_b_ff <= i_second_source;
        s1_rm_ff <= rm;
      end
    end
  end

  // Subtract datapath: flush, specials, align, add, normalise, round
  reg [31:0] sx, sy, sb_val;
  reg [6:0] sb_fl;
  reg [38:0] sr;
  reg sgn, eff;
  reg [7:0] eb, es, d;
  reg [23:0] mb, ms;
  reg [53:0] al;
  reg [27:0] sum;
  reg [26:0] nm;
  reg signed [10:0] ne;
  integer i;
  always @* begin
    sb_fl = 7'h0;
    sb_val = `FPSQ_QNAN;
    sx = s1_a_ff;
    sy = {~s1_b_ff[31], s1_b_ff[30:0]};
    sgn = 1'b0; eff = 1'b0; eb = 8'h0; es = 8'h0; d = 8'h0;
    mb = 24'h0; ms = 24'h0; al = 54'h0; sum = 28'h0; nm = 27'h0; ne = 11'sh0;
    sr = 39'h0;
    if (sx[30:23] == 8'h0 && sx[22:0] != 23'h0) begin
      sx = {sx[31], 31'h0};
      sb_fl[`FPSQ_FL_IFZ] = 1'b1;
    end
    if (sy[30:23] == 8'h0 && sy[22:0] != 23'h0) begin
      sy = {sy[31], 31'h0};
      sb_fl[`FPSQ_FL_IFZ] = 1'b1;
    end
    if ((sx[30:23] == 8'hff && sx[22:0] != 23'h0) || (sy[30:23] == 8'hff && sy[22:0] != 23'h0)) begin
      sb_fl[`FPSQ_FL_INV] = (sx[30:22] == 9'h1fe && sx[21:0] != 22'h0) ||
        (sy[30:22] == 9'h1fe && sy[21:0] != 22'h0);
    end else if (sx[30:0] == `FPSQ_INF_MAG && sy[30:0] == `FPSQ_INF_MAG) begin
      if (sx[31] != sy[31]) begin
        sb_fl[`FPSQ_FL_INV] = 1'b1;
      end else begin
        sb_val = sx;
      end
    end else if (sx[30:0] == `FPSQ_INF_MAG) begin
      sb_val = sx;
    end else if (sy[30:0] == `FPSQ_INF_MAG) begin
      sb_val = sy;
    end else begin
      // Larger magnitude leads so a true subtraction never goes negative
      if (sx[30:0] >= sy[30:0]) begin
        sgn = sx[31]; eb = sx[30:23]; es = sy[30:23];
        mb = {(eb != 8'h0), sx[22:0]}; ms = {(es != 8'h0), sy[22:0]};
      end else begin
        sgn = sy[31]; eb = sy[30:23]; es = sx[30:23];
        mb = {(eb != 8'h0), sy[22:0]}; ms = {(es != 8'h0), sx[22:0]};
      end
      eff = sx[31] ^ sy[31];
      d = eb - es;
      al = {ms, 3'h0, 27'h0} >> ((d > 8'h1b) ? 8'h1b : d);
      al[27] = al[27] | (|al[26:0]);
      sum = eff ? ({1'b0, mb, 3'h0} - {1'b0, al[53:27]}) : ({1'b0, mb, 3'h0} + {1'b0, al[53:27]});
      ne = $signed({3'h0, eb});
      if (sum[27]) begin
        nm = {sum[27:2], sum[1] | sum[0]};
        ne = ne + 11'sh1;
      end else begin
        nm = sum[26:0];
        for (i = 0; i < 27; i = i + 1) begin
          if (!nm[26] && nm != 27'h0) begin
            nm = {nm[25:0], 1'b0};
            ne = ne - 11'sh1;
          end
        end
      end
      // Exact zero from opposite signs is +0 except when rounding down
      if (nm == 27'h0 && eff) begin
        sgn = (s1_rm_ff == `FPSQ_RM_RM);
      end
      sr = fpsq_rnd(sgn, ne, nm, s1_rm_ff);
      sb_val = sr[31:0];
      sb_fl = sb_fl | sr[38:32];
    end
  end

  // Subtract stages 2 and 3 give the documented three-cycle latency
  reg s2_vld_ff, s2_gate_ff, s3_vld_ff, s3_gate_ff;
  reg [IDXW-1:0] s2_idx_ff, s3_idx_ff;
  reg [31:0] s2_val_ff, s3_val_ff;
  reg [6:0] s2_fl_ff, s3_fl_ff;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      s2_vld_ff <= 1'b0; s2_gate_ff <= 1'b0; s2_idx_ff <= {IDXW{1'b0}};
      s2_val_ff <= 32'h0; s2_fl_ff <= 7'h0;
      s3_vld_ff <= 1'b0; s3_gate_ff <= 1'b0; s3_idx_ff <= {IDXW{1'b0}};
      s3_val_ff <= 32'h0; s3_fl_ff <= 7'h0;
    end else begin
      s2_vld_ff <= s1_vld_ff; s2_gate_ff <= s1_gate_ff; s2_idx_ff <= s1_idx_ff;
      s2_val_ff <= sb_val; s2_fl_ff <= sb_fl;
      s3_vld_ff <= s2_vld_ff; s3_gate_ff <= s2_gate_ff; s3_idx_ff <= s2_idx_ff;
      s3_val_ff <= s2_val_ff; s3_fl_ff <= s2_fl_ff;
    end
  end

  // Flag sets land on the same edge as the destination writes
  wire sub_w = s3_vld_ff & s3_gate_ff;
  wire sq_w = sq_st_vld_ff & sq_st_gate_ff;
  wire [6:0] sets = (sub_w ? s3_fl_ff : 7'h0) |
    ((sq_w & ~sq_st_isfl_ff) ? sq_st_fl_ff : 7'h0) | i_ext_flags;
  // A set in the same cycle as an explicit write still wins
  wire [31:0] nxt_sw = (i_sw_wr ? i_sw_wdata : sw_ff) | {25'h0, sets};

  // Output and status registers
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      sw_ff <= `FPSQ_SW_RST;
      o_status_word <= `FPSQ_SW_RST;
      o_sub_wr <= 1'b0;
      o_sub_idx <= {IDXW{1'b0}};
      o_sub_data <= 32'h0;
      o_sqrt_wr <= 1'b0;
      o_sqrt_idx <= {IDXW{1'b0}};
      o_sqrt_data <= 32'h0;
      o_sqrt_busy <= 1'b0;
      o_refused <= 1'b0;
    end else begin
      sw_ff <= nxt_sw;
      o_status_word <= nxt_sw;
      o_sub_wr <= sub_w;
      o_sub_idx <= s3_idx_ff;
      o_sub_data <= s3_val_ff;
      o_sqrt_wr <= sq_w;
      o_sqrt_idx <= sq_st_idx_ff;
      o_sqrt_data <= sq_st_isfl_ff ? {25'h0, sq_st_fl_ff} : sq_st_val_ff;
      o_sqrt_busy <= (nxt_sq_cnt != 5'h0) && (nxt_sq_cnt < `FPSQ_SQRT_REC);
      o_refused <= refuse;
    end
  end
endmodule // fpsq_top
`default_nettype wire

/* tb/fpsq_asserts.sv */
// Timing, refusal and status-flag checks bound to the datapath top
`timescale 1ns/1ps
`default_nettype none
`include "fpsq_consts.vh"
module fpsq_asserts (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst, // Sync reset
  input wire logic i_issue_vld, // Issue strobe
  input wire logic [7:0] i_opcode, // Operation code
  input wire logic [2:0] i_slot, // Issue slot
  input wire logic i_guard_present, // Guard given
  input wire logic i_guard_lsb, // Guard bit 0
  input wire logic i_sw_wr, // Status write
  input wire logic [31:0] i_sw_wdata, // Status write data
  input wire logic [6:0] i_ext_flags, // Flags from other units
  input wire logic o_sub_wr, // Subtract write
  input wire logic o_sqrt_wr, // Root unit write
  input wire logic o_sqrt_busy, // Root unit recovering
  input wire logic o_refused, // Issue dropped
  input wire logic [31:0] o_status_word // Status word
);
  logic [4:0] rec_ff;
  wire sq_op = i_issue_vld && (i_opcode == `FPSQ_OP_SQRT || i_opcode == `FPSQ_OP_SQFL);
  wire sq_acc = sq_op && i_slot == `FPSQ_SLOT_SQRT && rec_ff == 5'h0;
  wire sb_op = i_issue_vld && i_opcode == `FPSQ_OP_SUB;
  wire sb_acc = sb_op && (i_slot == 3'h1 || i_slot == 3'h4);
  wire go = !i_guard_present || i_guard_lsb;
  // Own copy of the recovery count, so busy is judged independently
  always @(posedge i_ref_clk) begin
    if (i_rst)
      rec_ff <= 5'h0;
    else if (sq_acc)
      rec_ff <= 5'hf;
    else if (rec_ff != 5'h0)
      rec_ff <= rec_ff - 5'h1;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_sub_lat;
    sb_acc && go |-> ##4 o_sub_wr;
  endproperty
  a_sub_lat: assert property (p_sub_lat) else $error("sub write missing");
  property p_sub_grd;
    sb_acc && !go |-> ##4 !o_sub_wr;
  endproperty
  a_sub_grd: assert property (p_sub_grd) else $error("guarded sub wrote");
  property p_sq_lat;
    sq_acc && go |-> ##18 o_sqrt_wr;
  endproperty
  a_sq_lat: assert property (p_sq_lat) else $error("root write missing");
  property p_busy;
    o_sqrt_busy == (rec_ff != 5'h0);
  endproperty
  a_busy: assert property (p_busy) else $error("busy span wrong");
  property p_refuse;
    sq_op && rec_ff != 5'h0 |=> o_refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("busy issue kept");
  property p_bad_op;
    i_issue_vld && !sq_op && !sb_op |=> o_refused;
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("bad code kept");
  property p_sticky;
    !i_sw_wr |=> (o_status_word[6:1] & $past(o_status_word[6:1])) == $past(o_status_word[6:1]);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_ext_or;
    !i_sw_wr && i_ext_flags != 7'h0 |=> (o_status_word[6:0] & $past(i_ext_flags)) == $past(i_ext_flags);
  endproperty
  a_ext_or: assert property (p_ext_or) else $error("flag set lost");
  property p_when;
    !i_sw_wr && i_ext_flags == 7'h0 |=> $stable(o_status_word) || o_sub_wr || o_sqrt_wr;
  endproperty
  a_when: assert property (p_when) else $error("status moved alone");
  property p_mode;
    i_sw_wr |=> o_status_word[8:7] == $past(i_sw_wdata[8:7]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not written");
endmodule // fpsq_asserts
bind fpsq_top fpsq_asserts u_fpsq_asserts (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_issue_vld(i_issue_vld), .i_opcode(i_opcode), .i_slot(i_slot),
  .i_guard_present(i_guard_present), .i_guard_lsb(i_guard_lsb), .i_sw_wr(i_sw_wr),
  .i_sw_wdata(i_sw_wdata), .i_ext_flags(i_ext_flags), .o_sub_wr(o_sub_wr),
  .o_sqrt_wr(o_sqrt_wr), .o_sqrt_busy(o_sqrt_busy), .o_refused(o_refused),
  .o_status_word(o_status_word));
`default_nettype wire

/* tb/fpsq_issue_model.sv */
// Issue logic model of the core, one operation per call
`timescale 1ns/1ps
`default_nettype none
module fpsq_issue_model (
  input wire logic i_ref_clk, // Clock
  output var logic o_issue_vld, // Issue strobe
  output var logic [7:0] o_opcode, // Operation code
  output var logic [2:0] o_slot, // Issue slot
  output var logic [31:0] o_first_source, // First operand
  output var logic [31:0] o_second_source, // Second operand
  output var logic o_guard_present, // Guard given
  output var logic o_guard_lsb, // Guard bit 0
  output var logic [6:0] o_dest_idx // Destination index
);
  initial begin
    o_issue_vld = 1'b0;
    o_opcode = 8'h0;
    o_slot = 3'h0;
    o_first_source = 32'h0;
    o_second_source = 32'h0;
    o_guard_present = 1'b0;
    o_guard_lsb = 1'b0;
    o_dest_idx = 7'h0;
  end
  // Held for one whole cycle; operands inverted when idle so stale data never looks valid
  task automatic issue(input logic [7:0] op, input logic [2:0] sl, input logic [31:0] a, b,
    input logic gp, gl);
    @(negedge i_ref_clk);
    o_issue_vld = 1'b1;
    o_opcode = op;
    o_slot = sl;
    o_first_source = a;
    o_second_source = b;
    o_guard_present = gp;
    o_guard_lsb = gl;
    @(negedge i_ref_clk);
    o_issue_vld = 1'b0;
    o_first_source = ~a;
    o_second_source = ~b;
    o_dest_idx = o_dest_idx + 7'h1;
  endtask
endmodule // fpsq_issue_model
`default_nettype wire

/* tb/fpsq_top_tb_top.sv */
// Self-checking bench for the root and subtract datapath
`timescale 1ns/1ps
`default_nettype none
`include "fpsq_consts.vh"
module fpsq_top_tb_top;
  logic i_ref_clk = 1'b0;
  logic i_rst, i_sw_wr;
  logic [31:0] i_sw_wdata;
  logic [6:0] i_ext_flags;
  wire logic vld, gp, gl, o_sub_wr, o_sqrt_wr, o_sqrt_busy, o_refused;
  wire logic [7:0] op;
  wire logic [2:0] sl;
  wire logic [31:0] a, b, o_sub_data, o_sqrt_data, o_status_word;
  wire logic [6:0] idx, sub_idx, sqrt_idx;
  int checks = 0;
  int num_errors = 0;
  int cyc = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  fpsq_issue_model u_fpsq_issue_model (.i_ref_clk(i_ref_clk), .o_issue_vld(vld),
    .o_opcode(op), .o_slot(sl), .o_first_source(a), .o_second_source(b),
    .o_guard_present(gp), .o_guard_lsb(gl), .o_dest_idx(idx));
  fpsq_top u_fpsq_top (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_issue_vld(vld),
    .i_opcode(op), .i_slot(sl), .i_first_source(a), .i_second_source(b),
    .i_guard_present(gp), .i_guard_lsb(gl), .i_dest_idx(idx), .i_sw_wr(i_sw_wr),
    .i_sw_wdata(i_sw_wdata), .i_ext_flags(i_ext_flags), .o_sub_wr(o_sub_wr),
    .o_sub_idx(sub_idx), .o_sub_data(o_sub_data), .o_sqrt_wr(o_sqrt_wr),
    .o_sqrt_idx(sqrt_idx),
    .o_sqrt_data(o_sqrt_data), .o_sqrt_busy(o_sqrt_busy), .o_refused(o_refused),
    .o_status_word(o_status_word));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic set_sw(input logic [31:0] w);
    @(negedge i_ref_clk);
    i_sw_wr = 1'b1;
    i_sw_wdata = w;
    @(negedge i_ref_clk);
    i_sw_wr = 1'b0;
  endtask
  // Latency 25 means no write is expected at all
  task automatic do_op(input logic [7:0] c, input logic [2:0] s, input logic [31:0] x, y,
    input logic g, l, input int lat, input logic [31:0] d, st);
    int n;
    logic sub;
    logic [6:0] di;
    sub = (c == `FPSQ_OP_SUB);
    di = idx;
    u_fpsq_issue_model.issue(c, s, x, y, g, l);
    // n counts edges after the issue edge; the write is seen half a cycle later
    n = 0;
    while (((sub ? o_sub_wr : o_sqrt_wr) !== 1'b1) && n < 25) begin
      @(negedge i_ref_clk);
      n++;
    end
    chk("latency", 32'(lat), 32'(n));
    if (lat < 25) begin
      chk("data", d, sub ? o_sub_data : o_sqrt_data);
      chk("index", {25'h0, di}, {25'h0, sub ? sub_idx : sqrt_idx});
    end
    chk("status", st, o_status_word);
  endtask
  task automatic t_sqrt();
    set_sw(32'h0);
    do_op(`FPSQ_OP_SQRT, 3'h2, 32'h40400000, 32'h0, 0, 0, 17, 32'h3fddb3d7, 32'h2);
    do_op(`FPSQ_OP_SQRT, 3'h2, 32'h7f800000, 32'h0, 0, 0, 17, 32'h7f800000, 32'h2);
    set_sw(32'h0);
    do_op(`FPSQ_OP_SQRT, 3'h2, 32'h00400000, 32'h0, 0, 0, 17, 32'h0, 32'h20);
    do_op(`FPSQ_OP_SQRT, 3'h2, 32'hc0400000, 32'h0, 0, 0, 17, 32'hffffffff, 32'h30);
    do_op(`FPSQ_OP_SQRT, 3'h2, 32'h00c00000, 32'h0, 0, 0, 17, 32'h201cc471, 32'h32);
    $display("root test done");
  endtask
  task automatic t_flags();
    set_sw(32'h0);
    do_op(`FPSQ_OP_SQFL, 3'h2, 32'hc0400000, 32'h0, 0, 0, 17, 32'h10, 32'h0);
    do_op(`FPSQ_OP_SQFL, 3'h2, 32'h40400000, 32'h0, 0, 0, 17, 32'h2, 32'h0);
    do_op(`FPSQ_OP_SQFL, 3'h2, 32'h00400000, 32'h0, 0, 0, 17, 32'h20, 32'h0);
    do_op(`FPSQ_OP_SQFL, 3'h2, 32'h40400000, 32'h0, 1, 1, 17, 32'h2, 32'h0);
    do_op(`FPSQ_OP_SQFL, 3'h2, 32'h40400000, 32'h0, 1, 0, 25, 32'h0, 32'h0);
    $display("flag vector test done");
  endtask
  task automatic t_sub();
    logic [31:0] t [0:7][0:3] = '{'{32'hc0400000, 32'h3f800000, 32'hc0800000, 32'h0},
      '{32'h7f800000, 32'h7f800000, 32'hffffffff, 32'h10},
      '{32'h7f7fffff, 32'hff7fffff, 32'h7f800000, 32'ha},
      '{32'hffbfffff, 32'h3f800000, 32'hffffffff, 32'h10},
      '{32'hffffffff, 32'h3f800000, 32'hffffffff, 32'h0},
      '{32'h00c00000, 32'h00800000, 32'h0, 32'h40},
      '{32'h00800001, 32'h00800000, 32'h0, 32'h4},
      '{32'h40400000, 32'h00400000, 32'h40400000, 32'h20}};
    for (int i = 0; i < 8; i++) begin
      set_sw(32'h0);
      do_op(`FPSQ_OP_SUB, i[0] ? 3'h4 : 3'h1, t[i][0], t[i][1], 0, 0, 3, t[i][2], t[i][3]);
    end
    $display("subtract test done");
  endtask
  task automatic t_guard();
    set_sw(32'h0);
    do_op(`FPSQ_OP_SUB, 3'h1, 32'h7f800000, 32'h7f800000, 1, 0, 25, 32'h0, 32'h0);
    do_op(`FPSQ_OP_SUB, 3'h4, 32'h7f800000, 32'h7f800000, 1, 1, 3, 32'hffffffff, 32'h10);
    do_op(`FPSQ_OP_SQRT, 3'h2, 32'h00400000, 32'h0, 1, 0, 25, 32'h0, 32'h10);
    $display("guard test done");
  endtask
  // Busy unit, bad code and wrong slots: each dropped without a trace
  task automatic t_refuse();
    logic [7:0] c [0:3] = '{`FPSQ_OP_SQFL, 8'h70, `FPSQ_OP_SQRT, `FPSQ_OP_SUB};
    logic [2:0] s [0:3] = '{3'h2, 3'h2, 3'h1, 3'h2};
    set_sw(32'h0);
    u_fpsq_issue_model.issue(`FPSQ_OP_SQRT, 3'h2, 32'h40400000, 32'h0, 0, 0);
    chk("busy", 32'h1, 32'(o_sqrt_busy));
    for (int i = 0; i < 4; i++) begin
      u_fpsq_issue_model.issue(c[i], s[i], 32'hff800000, 32'hff800000, 0, 0);
      chk("refused", 32'h1, 32'(o_refused));
    end
    // Edge 15 after the accept is still refused, edge 17 is taken
    repeat (5) @(negedge i_ref_clk);
    u_fpsq_issue_model.issue(`FPSQ_OP_SQRT, 3'h2, 32'h40400000, 32'h0, 0, 0);
    chk("refused", 32'h1, 32'(o_refused));
    chk("busy", 32'h0, 32'(o_sqrt_busy));
    u_fpsq_issue_model.issue(`FPSQ_OP_SQRT, 3'h2, 32'h40400000, 32'h0, 0, 0);
    chk("refused", 32'h0, 32'(o_refused));
    repeat (20) @(negedge i_ref_clk);
    chk("status", 32'h2, o_status_word);
    $display("refusal test done");
  endtask
  task automatic t_round();
    logic [31:0] d;
    for (int m = 0; m < 4; m++) begin
      set_sw({23'h0, 2'(m), 7'h0});
      d = (m == 1 || m == 3) ? 32'h403fffff : 32'h40400000;
      do_op(`FPSQ_OP_SUB, 3'h1, 32'h40400000, 32'h00800000, 0, 0, 3, d, {23'h0, 2'(m), 7'h2});
    end
    $display("rounding test done");
  endtask
  task automatic t_or();
    set_sw(32'h0);
    @(negedge i_ref_clk);
    i_ext_flags = 7'h40;
    @(negedge i_ref_clk);
    i_ext_flags = 7'h04;
    chk("status", 32'h40, o_status_word);
    do_op(`FPSQ_OP_SUB, 3'h1, 32'h40400000, 32'h00800000, 0, 0, 3, 32'h40400000, 32'h46);
    i_ext_flags = 7'h0;
    do_op(`FPSQ_OP_SUB, 3'h4, 32'hc0400000, 32'h3f800000, 0, 0, 3, 32'hc0800000, 32'h46);
    set_sw(32'h0);
    chk("status", 32'h0, o_status_word);
    $display("flag merge test done");
  endtask
  initial begin
    i_rst = 1'b1;
    i_sw_wr = 1'b0;
    i_sw_wdata = 32'h0;
    i_ext_flags = 7'h0;
    repeat (5) @(negedge i_ref_clk);
    i_rst = 1'b0;
    chk("status", 32'h0, o_status_word);
    t_sqrt();
    t_flags();
    t_sub();
    t_guard();
    t_refuse();
    t_round();
    t_or();
    give_verdict();
  end
endmodule // fpsq_top_tb_top
`default_nettype wire
